/* hdl/csr_clock_status_regs.sv */
// wishbone register slice: clock status, interrupt mask and fast wakeup mode
`timescale 1ns/100ps
module csr_clock_status_regs
	import csr_pkg::*;
(
	input  wire logic                      core_clk,       // 250 MHz clock
	input  wire logic                      rst_b,          // async reset, active low
	input  wire logic                      wb_cyc_i,       // bus cycle
	input  wire logic                      wb_stb_i,       // strobe
	input  wire logic                      wb_we_i,        // write enable
	input  wire logic [31:0]               wb_adr_i,       // byte address
	input  wire logic [3:0]                wb_sel_i,       // byte lanes
	input  wire logic [31:0]               wb_dat_i,       // write data
	output logic      [31:0]               wb_dat_o,       // read data
	output logic                           wb_ack_o,       // acknowledge
	input  wire csr_clk_stat_t             clk_stat,       // clock status levels, asynchronous
	input  wire logic                      fail_pulse,     // failure detection pulse, same clock
	input  wire logic [CSR_WAKE_IN_NUM-1:0] wake_in,       // wake-up inputs, asynchronous
	input  wire logic                      timer_alarm,    // timer alarm, asynchronous
	input  wire logic                      calendar_alarm, // calendar alarm, asynchronous
	output csr_power_ctl_t                 power_ctl,      // power mode control
	output logic                           irq             // interrupt request
);
	// synchroniser stages for the asynchronous inputs
	csr_clk_stat_t              stat_meta;     // first stage
	csr_clk_stat_t              stat_sync;     // second stage
	logic [CSR_WAKE_IN_NUM+1:0] wake_meta;     // first stage, alarms on top
	logic [CSR_WAKE_IN_NUM+1:0] wake_sync;     // second stage
	logic                       fail_event;    // sticky failure event
	logic                       xt32_err;      // sticky slow crystal error
	logic [31:0]                irq_mask;      // interrupt mask
	logic [31:0]                wake_mode;     // fast wakeup mode register
	logic                       protect_en;    // write protect enable
	logic [31:0]                status_word;   // assembled status
	logic [31:0]                wr_mask;       // byte lane write mask
	logic [CSR_PCK_NUM-1:0]     pck_bits;      // per-clock ready bits
	logic                       req;           // new bus request
	logic                       wr_req;        // write request
	logic                       rd_status;     // status read this cycle
	logic [CSR_WAKE_IN_NUM+1:0] wake_gated;    // enabled wake sources
	logic                       next_irq;      // interrupt level

	// a request is taken in the cycle ack is low, so ack is one cycle per request
	assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_req    = req && wb_we_i;
	assign rd_status = req && !wb_we_i && (wb_adr_i == CSR_STATUS_ADDR);

	// expand byte enables into a bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			assign wr_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
		end
		for (gi = 0; gi < CSR_PCK_NUM; gi++) begin : g_pck
			assign pck_bits[gi] = stat_sync.prog_clock_ready[gi]; // R7
		end
	endgenerate

	// two-flop synchronisers for status levels and wake sources
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_meta <= '0;
			stat_sync <= '0;
			wake_meta <= '0;
			wake_sync <= '0;
		end else begin
			stat_meta <= clk_stat;
			stat_sync <= stat_meta;
			wake_meta <= {calendar_alarm, timer_alarm, wake_in};
			wake_sync <= wake_meta;
		end
	end

	// sticky failure event: a new pulse wins over the clearing read
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			fail_event <= 1'b0;
		end else if (fail_pulse) begin
			fail_event <= 1'b1; // R10
		end else if (rd_status) begin
			fail_event <= 1'b0; // R10
		end
	end

	// slow crystal error holds while monitoring stays enabled
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			xt32_err <= 1'b0;
		end else if (!stat_sync.slow_xtal_mon_en) begin
			xt32_err <= 1'b0; // R13
		end else if (stat_sync.slow_xtal_bad) begin
			xt32_err <= 1'b1; // R13
		end
	end

	// status word layout shared with mask registers
	always_comb begin
		status_word                   = '0;
		status_word[CSR_MAIN_XTAL_BIT] = stat_sync.main_xtal_stable;     // R3 R2
		status_word[CSR_PLL_A_BIT]    = stat_sync.pll_a_locked;          // R4
		status_word[CSR_PLL_B_BIT]    = stat_sync.pll_b_locked;          // R4
		status_word[CSR_MCK_BIT]      = stat_sync.master_clock_ready;    // R5
		status_word[CSR_SLOW_SEL_BIT] = stat_sync.slow_osc_is_crystal;   // R6
		status_word[CSR_PCK_LSB +: CSR_PCK_NUM] = pck_bits;             // R7
		status_word[CSR_SRC_SEL_BIT]  = stat_sync.main_source_sel_done;  // R8
		status_word[CSR_RC_BIT]       = stat_sync.rc_osc_stable;         // R9
		status_word[CSR_FAIL_EV_BIT]  = fail_event;                      // R10
		status_word[CSR_FAIL_NOW_BIT] = stat_sync.clk_fail_now;          // R11
		status_word[CSR_FAULT_BIT]    = stat_sync.fault_out_active;      // R12
		status_word[CSR_XT32_ERR_BIT] = xt32_err;                        // R13
	end

	// interrupt mask: enable sets, disable clears, only in implemented bits
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_mask <= CSR_MASK_RESET; // R22
		end else if (wr_req && wb_adr_i == CSR_IRQ_ENABLE_ADDR) begin
			irq_mask <= irq_mask | (wb_dat_i & wr_mask & CSR_IRQ_BITS); // R20
		end else if (wr_req && wb_adr_i == CSR_IRQ_DISABLE_ADDR) begin
			irq_mask <= irq_mask & ~(wb_dat_i & wr_mask & CSR_IRQ_BITS); // R1 R2
		end
	end

	// write protection: key in upper bits must match
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			protect_en <= 1'b0;
		end else if (wr_req && wb_adr_i == CSR_PROTECT_ADDR && wb_sel_i == 4'hF
			&& wb_dat_i[31:8] == CSR_PROTECT_KEY[31:8]) begin
			protect_en <= wb_dat_i[CSR_PROTECT_BIT];
		end
	end

	// fast wakeup mode register, locked while protected
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_mode <= CSR_WAKE_RESET; // R22
		end else if (wr_req && wb_adr_i == CSR_WAKE_MODE_ADDR && !protect_en) begin // R15
			wake_mode <= (wake_mode & ~(wr_mask & CSR_WAKE_BITS)) | (wb_dat_i & wr_mask & CSR_WAKE_BITS);
		end
	end

	// gate wake inputs and alarms by their enables
	assign wake_gated = wake_sync & wake_mode[CSR_CAL_AL_BIT:0]; // R16 R17

	// power control outputs from flip-flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			power_ctl <= '0;
		end else begin
			power_ctl.fast_restart     <= |wake_gated;                       // R16 R17
			power_ctl.sleep_on_wait    <= !wake_mode[CSR_LP_SEL_BIT];        // R18
			power_ctl.wait_on_event    <= wake_mode[CSR_LP_SEL_BIT];         // R18
			power_ctl.flash_wait_state <= wake_mode[CSR_FLASH_LSB +: 2];    // R19
		end
	end

	// interrupt level from masked status
	assign next_irq = |(status_word & irq_mask & CSR_IRQ_BITS);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq; // R21
		end
	end

	// bus answer: one cycle after request, unmapped reads give zero
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				case (wb_adr_i)
					CSR_STATUS_ADDR:    wb_dat_o <= status_word;  // R2
					CSR_MASK_VIEW_ADDR: wb_dat_o <= irq_mask;     // R14
					CSR_WAKE_MODE_ADDR: wb_dat_o <= wake_mode;
					CSR_PROTECT_ADDR:   wb_dat_o <= {31'h0, protect_en};
					default:            wb_dat_o <= '0;           // write-only and unmapped
				endcase
			end
		end
	end

	// assertions
	a_disable_clears: assert property (@(posedge core_clk) disable iff (!rst_b) // R1
		wr_req && wb_adr_i == CSR_IRQ_DISABLE_ADDR && wb_sel_i == 4'hF && wb_dat_i[CSR_MCK_BIT]
		|=> !irq_mask[CSR_MCK_BIT]) else $error("disable write left mask bit set");
	a_enable_sets: assert property (@(posedge core_clk) disable iff (!rst_b) // R20
		wr_req && wb_adr_i == CSR_IRQ_ENABLE_ADDR && wb_sel_i == 4'hF && wb_dat_i[CSR_RC_BIT]
		|=> irq_mask[CSR_RC_BIT]) else $error("enable write left mask bit clear");
	a_mask_reserved: assert property (@(posedge core_clk) disable iff (!rst_b) // R2
		(irq_mask & ~CSR_IRQ_BITS) == 32'h0) else $error("reserved mask bit set");
	a_fail_sticky: assert property (@(posedge core_clk) disable iff (!rst_b) // R10
		fail_pulse |=> fail_event) else $error("failure event lost");
	a_fail_read_clr: assert property (@(posedge core_clk) disable iff (!rst_b) // R10
		rd_status && !fail_pulse |=> !fail_event) else $error("failure event not cleared by read");
	a_pll_follows: assert property (@(posedge core_clk) disable iff (!rst_b) // R4
		$rose(clk_stat.pll_a_locked) ##1 clk_stat.pll_a_locked |=> status_word[CSR_PLL_A_BIT])
		else $error("pll lock not shown after two cycles");
	a_protect_locks: assert property (@(posedge core_clk) disable iff (!rst_b) // R15
		wr_req && wb_adr_i == CSR_WAKE_MODE_ADDR && protect_en |=> $stable(wake_mode))
		else $error("protected wakeup mode changed");
	a_irq_level: assert property (@(posedge core_clk) disable iff (!rst_b) // R21
		|(status_word & irq_mask) |=> irq) else $error("masked status gave no interrupt");
	a_lp_select: assert property (@(posedge core_clk) disable iff (!rst_b) // R18
		wake_mode[CSR_LP_SEL_BIT] |=> power_ctl.wait_on_event && !power_ctl.sleep_on_wait)
		else $error("low power select not applied");
	a_ack_one: assert property (@(posedge core_clk) disable iff (!rst_b)
		wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");

	// every taken request is answered in the very next cycle
	a_ack_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
		req |=> wb_ack_o) else $error("request not answered");

	// status read returns the assembled status word
	a_status_read: assert property (@(posedge core_clk) disable iff (!rst_b) // R2
		rd_status |=> wb_dat_o == $past(status_word)) else $error("status read data wrong");

	// mask view read returns the live mask
	a_mask_read: assert property (@(posedge core_clk) disable iff (!rst_b) // R14
		req && !wb_we_i && wb_adr_i == CSR_MASK_VIEW_ADDR |=> wb_dat_o == $past(irq_mask))
		else $error("mask view read data wrong");

	// write-only enable register reads as zero
	a_enable_rd_zero: assert property (@(posedge core_clk) disable iff (!rst_b) // R20
		req && !wb_we_i && wb_adr_i == CSR_IRQ_ENABLE_ADDR |=> wb_dat_o == 32'h00000000)
		else $error("enable register read not zero");

	// only documented wakeup mode bits ever hold a one
	a_wake_reserved: assert property (@(posedge core_clk) disable iff (!rst_b) // R22
		(wake_mode & ~CSR_WAKE_BITS) == 32'h00000000) else $error("reserved wakeup bit set");

	// slow crystal error clears while monitoring is off
	a_xt32_clear: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
		!stat_sync.slow_xtal_mon_en |=> !xt32_err) else $error("slow crystal error kept unmonitored");

	// slow crystal error sets on a bad frequency while monitored
	a_xt32_set: assert property (@(posedge core_clk) disable iff (!rst_b) // R13
		stat_sync.slow_xtal_mon_en && stat_sync.slow_xtal_bad |=> xt32_err)
		else $error("slow crystal error not set");

	// an enabled wake source raises fast restart
	a_restart_set: assert property (@(posedge core_clk) disable iff (!rst_b) // R16
		|wake_gated |=> power_ctl.fast_restart) else $error("enabled wake source ignored");

	// disabled wake sources have no effect
	a_restart_quiet: assert property (@(posedge core_clk) disable iff (!rst_b) // R17
		wake_gated == '0 |=> !power_ctl.fast_restart) else $error("fast restart without source");

	// clear low power select gives sleep on any wait
	a_sleep_select: assert property (@(posedge core_clk) disable iff (!rst_b) // R18
		!wake_mode[CSR_LP_SEL_BIT] |=> power_ctl.sleep_on_wait && !power_ctl.wait_on_event)
		else $error("sleep entry not selected");

	// flash state output follows its field
	a_flash_state: assert property (@(posedge core_clk) disable iff (!rst_b) // R19
		1'b1 |=> power_ctl.flash_wait_state == $past(wake_mode[CSR_FLASH_LSB +: 2]))
		else $error("flash wait state not applied");

	// unprotected wakeup write lands at the take edge
	a_wake_write: assert property (@(posedge core_clk) disable iff (!rst_b) // R15
		wr_req && wb_adr_i == CSR_WAKE_MODE_ADDR && !protect_en && wb_sel_i == 4'hF
		|=> wake_mode == ($past(wb_dat_i) & CSR_WAKE_BITS)) else $error("wakeup write lost");

	// interrupt stays low with nothing masked in
	a_irq_quiet: assert property (@(posedge core_clk) disable iff (!rst_b) // R21
		(status_word & irq_mask) == 32'h00000000 |=> !irq) else $error("interrupt without source");

	c_fail_read: cover property (@(posedge core_clk) disable iff (!rst_b) fail_event ##1 rd_status);
	c_irq_rise: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(irq));
	c_restart: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(power_ctl.fast_restart));
	c_protected: cover property (@(posedge core_clk) disable iff (!rst_b)
		wr_req && protect_en && wb_adr_i == CSR_WAKE_MODE_ADDR);
	c_xt32_err: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(xt32_err));
endmodule

/* hdl/csr_pkg.sv */
// package with register map, field layout and types for the clock status register slice
// Overview of operation
// R1: disable write clears mask bits written one
// R2: disable, mask, status share one bit layout
// R3: status bit 0 shows main crystal stable
// R4: bits 1,2 show pll a/b locked
// R5: bit 3 shows master clock ready
// R6: bit 7 one when slow crystal selected
// R7: bits 8-10 show programmable clocks ready
// R8: bit 16 one once source selection done
// R9: bit 17 one once rc oscillator stable
// R10: bit 18 sticky failure event, read clears
// R11: bit 19 shows present failure detection
// R12: bit 20 shows fault output active
// R13: bit 21 slow crystal error, held while monitored
// R14: mask view reads enabled sources
// R15: wakeup mode ignores writes when protected
// R16: wakeup input enables gate fast restart
// R17: bits 16,17 gate timer and calendar alarms
// R18: bit 20 selects sleep or wait entry
// R19: bits 22:21 select flash wait state
// R20: enable write sets mask bits written one
// R21: interrupt while any masked status set
// R22: masks and wakeup mode reset to zero
package csr_pkg;
	localparam logic [31:0] CSR_IRQ_ENABLE_ADDR   = 32'h400E0460; // enable, write-only
	localparam logic [31:0] CSR_IRQ_DISABLE_ADDR  = 32'h400E0464; // disable, write-only
	localparam logic [31:0] CSR_STATUS_ADDR       = 32'h400E0468; // status, read-only
	localparam logic [31:0] CSR_MASK_VIEW_ADDR    = 32'h400E046C; // mask, read-only
	localparam logic [31:0] CSR_WAKE_MODE_ADDR    = 32'h400E0470; // fast wakeup mode
	localparam logic [31:0] CSR_PROTECT_ADDR      = 32'h400E0480; // write protection mode
	localparam int          CSR_MAIN_XTAL_BIT     = 0;            // main crystal stable
	localparam int          CSR_PLL_A_BIT         = 1;            // pll a locked
	localparam int          CSR_PLL_B_BIT         = 2;            // pll b locked
	localparam int          CSR_MCK_BIT           = 3;            // master clock ready
	localparam int          CSR_SLOW_SEL_BIT      = 7;            // slow osc is crystal
	localparam int          CSR_PCK_LSB           = 8;            // prog clock ready lsb
	localparam int          CSR_PCK_NUM           = 3;            // number of prog clocks
	localparam int          CSR_SRC_SEL_BIT       = 16;           // main source sel done
	localparam int          CSR_RC_BIT            = 17;           // rc osc stable
	localparam int          CSR_FAIL_EV_BIT       = 18;           // clk fail event
	localparam int          CSR_FAIL_NOW_BIT      = 19;           // clk fail now
	localparam int          CSR_FAULT_BIT         = 20;           // fault out active
	localparam int          CSR_XT32_ERR_BIT      = 21;           // slow xtal error
	localparam logic [31:0] CSR_IRQ_BITS          = 32'h0027070F; // implemented interrupt sources
	localparam logic [31:0] CSR_MASK_RESET        = 32'h00000000; // mask after reset
	localparam logic [31:0] CSR_WAKE_RESET        = 32'h00000000; // wakeup mode after reset
	localparam logic [31:0] CSR_WAKE_BITS         = 32'h0073FFFF; // writable wakeup mode bits
	localparam int          CSR_WAKE_IN_NUM       = 16;           // wakeup inputs
	localparam int          CSR_TIMER_AL_BIT      = 16;           // timer alarm enable
	localparam int          CSR_CAL_AL_BIT        = 17;           // calendar alarm enable
	localparam int          CSR_LP_SEL_BIT        = 20;           // low power select
	localparam int          CSR_FLASH_LSB         = 21;           // flash wait state lsb
	localparam logic [1:0]  CSR_FLASH_STANDBY     = 2'h0;         // flash standby
	localparam logic [1:0]  CSR_FLASH_DEEP        = 2'h1;         // flash deep power-down
	localparam logic [1:0]  CSR_FLASH_IDLE        = 2'h2;         // flash idle
	localparam logic [31:0] CSR_PROTECT_KEY       = 32'h5A5A5A00; // arbitrary key in bits 31:8
	localparam int          CSR_PROTECT_BIT       = 0;            // write protect enable

	// oscillator and clock status levels from the clock generators
	typedef struct packed {
		logic                   main_xtal_stable;     // main crystal stable
		logic                   pll_a_locked;         // pll a locked
		logic                   pll_b_locked;         // pll b locked
		logic                   master_clock_ready;   // master clock ready
		logic                   slow_osc_is_crystal;  // slow clock from crystal
		logic [CSR_PCK_NUM-1:0] prog_clock_ready;     // programmable clocks ready
		logic                   main_source_sel_done; // source selection done
		logic                   rc_osc_stable;        // rc oscillator stable
		logic                   clk_fail_now;         // failure detected now
		logic                   fault_out_active;     // fault output active
		logic                   slow_xtal_bad;        // slow crystal out of tolerance
		logic                   slow_xtal_mon_en;     // slow crystal monitor enabled
	} csr_clk_stat_t;

	// power control decoded from the fast wakeup mode register
	typedef struct packed {
		logic       fast_restart;     // fast restart request
		logic       sleep_on_wait;    // any wait instruction gives sleep
		logic       wait_on_event;    // event wait gives system wait mode
		logic [1:0] flash_wait_state; // flash state in wait mode
	} csr_power_ctl_t;
endpackage

/* verif/tb_csr_clock_status_regs.sv */
// self-checking bench for the clock status, interrupt mask and fast wakeup register slice
`timescale 1ns/100ps
module tb_csr_clock_status_regs;
	import csr_pkg::*;
	logic                       core_clk;       // 250 MHz clock
	logic                       rst_b;          // async reset, active low
	logic                       wb_cyc_i;       // bus cycle
	logic                       wb_stb_i;       // strobe
	logic                       wb_we_i;        // write enable
	logic [31:0]                wb_adr_i;       // byte address
	logic [3:0]                 wb_sel_i;       // byte lanes
	logic [31:0]                wb_dat_i;       // write data
	logic [31:0]                wb_dat_o;       // read data
	logic                       wb_ack_o;       // acknowledge
	csr_clk_stat_t              clk_stat;       // clock status levels
	logic                       fail_pulse;     // failure pulse
	logic [CSR_WAKE_IN_NUM-1:0] wake_in;        // wake-up inputs
	logic                       timer_alarm;    // timer alarm
	logic                       calendar_alarm; // calendar alarm
	csr_power_ctl_t             power_ctl;      // power mode control
	logic                       irq;            // interrupt request
	int                         err_count;      // mismatches
	int                         checked;        // comparisons
	int                         cycles;         // timeout counter
	logic [15:0]                lfsr;           // random source
	logic [31:0]                mask_m, wm_m, q, d, e; // model state and scratch
	logic                       evt_m, xe_m;    // sticky event and slow crystal error models
	csr_clk_stat_t              s;              // status picked this round
	logic                       prot;           // protection on this round

	csr_clock_status_regs u_dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .clk_stat(clk_stat), .fail_pulse(fail_pulse), .wake_in(wake_in),
		.timer_alarm(timer_alarm), .calendar_alarm(calendar_alarm), .power_ctl(power_ctl), .irq(irq));

	// free running clock, 4 ns period
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// hang guard: a run past the ceiling counts as a mismatch
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count++;
			stop_test();
		end
	end

	// next random word from the shift register
	function automatic logic [15:0] rnd(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// compare one value and count it
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one classic wishbone cycle, held until ack is sampled high
	task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hF;
		wb_dat_i <= wd;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) err_count++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	// expected status word built from the levels and the sticky models
	function automatic logic [31:0] stat_exp(input csr_clk_stat_t v, input logic ev, input logic xe);
		logic [31:0] r;
		r = 32'h00000000;
		r[0] = v.main_xtal_stable;
		r[1] = v.pll_a_locked;
		r[2] = v.pll_b_locked;
		r[3] = v.master_clock_ready;
		r[7] = v.slow_osc_is_crystal;
		r[10:8] = v.prog_clock_ready;
		r[16] = v.main_source_sel_done;
		r[17] = v.rc_osc_stable;
		r[18] = ev;
		r[19] = v.clk_fail_now;
		r[20] = v.fault_out_active;
		r[21] = xe;
		return r;
	endfunction

	// verdict and end of run
	task automatic stop_test();
		if (err_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// main sequence
	initial begin
		rst_b = 1'b0; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 32'h00000000;
		wb_sel_i = 4'h0; wb_dat_i = 32'h00000000; clk_stat = '0; fail_pulse = 1'b0; wake_in = 16'h0000;
		timer_alarm = 1'b0; calendar_alarm = 1'b0; err_count = 0; checked = 0; cycles = 0;
		lfsr = 16'h6A6B; mask_m = 32'h00000000; wm_m = 32'h00000000; evt_m = 1'b0; xe_m = 1'b0;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(32'(power_ctl), 32'(csr_power_ctl_t'{1'b0, 1'b1, 1'b0, 2'h0}));
		wb(1'b0, CSR_MASK_VIEW_ADDR, 32'h00000000, q); chk(q, 32'h00000000);
		wb(1'b0, CSR_WAKE_MODE_ADDR, 32'h00000000, q); chk(q, 32'h00000000);
		wb(1'b0, CSR_IRQ_ENABLE_ADDR, 32'h00000000, q); chk(q, 32'h00000000);
		wb(1'b0, 32'h400E0500, 32'h00000000, q); chk(q, 32'h00000000);
		for (int i = 0; i < 16; i++) begin
			// new status levels; slow crystal error held while monitored
			lfsr = rnd(lfsr); s = csr_clk_stat_t'(lfsr[13:0]);
			@(posedge core_clk); clk_stat <= s;
			if (!s.slow_xtal_mon_en) xe_m = 1'b0;
			else if (s.slow_xtal_bad) xe_m = 1'b1;
			// set then clear mask bits
			lfsr = rnd(lfsr); d = {lfsr, rnd(lfsr)}; lfsr = rnd(lfsr);
			wb(1'b1, CSR_IRQ_ENABLE_ADDR, d, q); mask_m = mask_m | (d & CSR_IRQ_BITS);
			lfsr = rnd(lfsr); d = {lfsr & rnd(lfsr), lfsr[7:0] & lfsr[15:8], 8'h00};
			wb(1'b1, CSR_IRQ_DISABLE_ADDR, d, q); mask_m = mask_m & ~d;
			wb(1'b0, CSR_MASK_VIEW_ADDR, 32'h00000000, q); chk(q, mask_m);
			// failure pulse on odd rounds, cleared by the read
			if (i % 2 == 1) begin
				@(posedge core_clk); fail_pulse <= 1'b1;
				@(posedge core_clk); fail_pulse <= 1'b0;
				evt_m = 1'b1;
			end
			repeat (3) @(posedge core_clk);
			e = stat_exp(s, evt_m, xe_m);
			chk(32'(irq), 32'(|(e & mask_m)));
			wb(1'b0, CSR_STATUS_ADDR, 32'h00000000, q);
			chk(q, e);
			evt_m = 1'b0;
			// wakeup mode, locked every fourth round
			prot = (i % 4 == 3);
			if (prot) wb(1'b1, CSR_PROTECT_ADDR, CSR_PROTECT_KEY | 32'h00000001, q);
			wb(1'b0, CSR_PROTECT_ADDR, 32'h00000000, q); chk(q, 32'(prot));
			lfsr = rnd(lfsr); d = {lfsr, rnd(lfsr)}; lfsr = rnd(lfsr);
			d[22:21] = 2'(i % 3);
			wb(1'b1, CSR_WAKE_MODE_ADDR, d, q);
			if (!prot) wm_m = d & CSR_WAKE_BITS;
			wb(1'b0, CSR_WAKE_MODE_ADDR, 32'h00000000, q); chk(q, wm_m);
			if (prot) wb(1'b1, CSR_PROTECT_ADDR, CSR_PROTECT_KEY, q);
			// wake sources against the enables
			lfsr = rnd(lfsr);
			@(posedge core_clk);
			wake_in <= lfsr & rnd(lfsr); timer_alarm <= lfsr[3]; calendar_alarm <= lfsr[9];
			repeat (5) @(posedge core_clk);
			e[0] = |(wake_in & wm_m[15:0]) | (timer_alarm & wm_m[16]) | (calendar_alarm & wm_m[17]);
			chk(32'(power_ctl.fast_restart), 32'(e[0]));
			chk(32'({power_ctl.sleep_on_wait, power_ctl.wait_on_event}), 32'({~wm_m[20], wm_m[20]}));
			chk(32'(power_ctl.flash_wait_state), 32'(wm_m[22:21]));
		end
		stop_test();
	end
endmodule
